// >>> inc/fpo_map.svh
/*
 Register map, field positions, command codes and reset values
 of the flash command sequencer. Assumes a 32-bit APB slave.
*/
`ifndef FPO_MAP_SVH
`define FPO_MAP_SVH
// Register offsets
`define OFS_STATUS 8'h00
`define OFS_SLOT_IDX 8'h04
`define OFS_SLOT_DATA 8'h08
`define OFS_CONFIG 8'h0c
// Status bits
`define B_CCF 7
`define B_ACC 5
`define B_FPV 4
`define B_VER 1
`define B_FAT 0
// Config fields: command enable, protection enable, first protected block
`define B_CMD_EN 0
`define B_PROT_EN 15
`define RST_CONFIG 16'h0001
// Command codes and the slot index each needs at launch
`define CMD_RD_ONCE 8'h04
`define CMD_PG_MAIN 8'h06
`define CMD_PG_ONCE 8'h07
`define IDX_RD_ONCE 3'h1
`define IDX_PROG 3'h5
`define ERASED 64'hffff_ffff_ffff_ffff
`endif

// >>> inc/fpo_pkg.sv
/*
 Types of the flash command sequencer: states, flash operations,
 the flash-side carriers and the whole module state.
*/
package fpo_pkg;
    typedef enum logic [2:0] {S_IDLE, S_RDO, S_ECHK, S_PROG, S_VER} st_e;
    typedef enum logic [1:0] {OP_RD_MAIN, OP_RD_INFO, OP_PG_MAIN, OP_PG_INFO} op_e;
    typedef struct packed {
        logic req;
        op_e op;
        logic [22:0] addr;
        logic [63:0] wdata;
    } fl_cmd_s;
    typedef struct packed {
        logic ack;
        logic err;
        logic fatal;
        logic [63:0] rdata;
    } fl_rsp_s;
    typedef struct packed {
        st_e st;
        logic ccf, acc, fpv, ver, fat;
        logic [2:0] idx;
        logic [5:0][15:0] slot;
        logic [15:0] cfg;
        logic info;
        fl_cmd_s fl;
        logic rd_inv_any, rd_inv_b0;
        logic pready, pslverr;
        logic [31:0] prdata;
    } state_s;
endpackage

// >>> rtl/flash_program_once_sequencer.sv
/*
 Flash command sequencer: read-once, program main flash and
 program-once, reached over APB. Assumes a flash array port that
 answers each held request with a one-cycle ack on pclk.
*/
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "fpo_map.svh"
module flash_program_once_sequencer
    import fpo_pkg::*;
#(
    parameter int OTP_PHRASES = 8,
    parameter logic [6:0] PF_FIRST_BLK = 7'h7c
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Flash array port
    output fl_cmd_s fl_cmd,
    input wire fl_rsp_s fl_rsp,
    // Ordinary-read invalid markers
    output logic rd_inv_any,
    output logic rd_inv_b0
);

////////////////////////////////////////////////////////////////////////////////

// The one-time field has eight phrases; fewer is allowed, more is not
generate
    if (OTP_PHRASES < 1 || OTP_PHRASES > 8)
    begin : g_bad
        $error("OTP_PHRASES must be 1 to 8");
    end
endgenerate

state_s q;
state_s d;
logic rd_acc;
logic wr_acc;
logic launch;
logic bad;
logic prot_hit;
logic [7:0] cmd;
logic [6:0] blk;

// Phrase index check shared by both one-time commands
function automatic logic phrase_ok(input logic [15:0] v);
    phrase_ok = v < 16'(OTP_PHRASES);
endfunction

assign cmd = q.slot[0][15:8];
assign blk = q.slot[0][6:0];

////////////////////////////////////////////////////////////////////////////////

// Next-state logic: bus, launch checks and the command sequence
always_comb
begin
    d = q;
    bad = 1'b0;
    prot_hit = 1'b0;
    launch = 1'b0;
    rd_acc = psel && penable && !q.pready;
    wr_acc = psel && penable && q.pready && pwrite;
    // One wait state: pready and read data come from flops
    d.pready = rd_acc;
    d.pslverr = 1'b0;
    d.prdata = '0;
    if (rd_acc)
    begin
        case (paddr)
            `OFS_STATUS:
            begin
                d.prdata[`B_CCF] = q.ccf;
                d.prdata[`B_ACC] = q.acc;
                d.prdata[`B_FPV] = q.fpv;
                d.prdata[`B_VER] = q.ver;
                d.prdata[`B_FAT] = q.fat;
            end
            `OFS_SLOT_IDX: d.prdata[2:0] = q.idx;
            `OFS_SLOT_DATA:
            begin
                if (q.idx <= 3'h5)
                begin
                    d.prdata[15:0] = q.slot[q.idx];
                end
            end
            `OFS_CONFIG: d.prdata[15:0] = q.cfg;
            default: d.pslverr = 1'b1;
        endcase
    end
    // Writes land at the edge where pready is seen high
    if (wr_acc)
    begin
        case (paddr)
            `OFS_STATUS:
            begin
                if (pwdata[`B_ACC])
                begin
                    d.acc = 1'b0;
                end
                if (pwdata[`B_FPV])
                begin
                    d.fpv = 1'b0;
                end
                launch = pwdata[`B_CCF] && q.ccf;
            end
            // Parameters are frozen while a command runs
            `OFS_SLOT_IDX:
            begin
                if (q.ccf)
                begin
                    d.idx = pwdata[2:0];
                end
            end
            `OFS_SLOT_DATA:
            begin
                if (q.ccf && q.idx <= 3'h5)
                begin
                    d.slot[q.idx] = pwdata[15:0];
                end
            end
            `OFS_CONFIG:
            begin
                if (q.ccf)
                begin
                    d.cfg = pwdata[15:0];
                end
            end
            default: ;
        endcase
    end
    // Launch: flags set here win over a clear in the same write
    if (launch)
    begin
        d.ver = 1'b0;
        d.fat = 1'b0;
        case (cmd)
            `CMD_RD_ONCE:
                bad = q.idx != `IDX_RD_ONCE || !phrase_ok(q.slot[1]);
            `CMD_PG_MAIN:
                bad = q.idx != `IDX_PROG || q.slot[1][2:0] != 3'b000
                    || blk < PF_FIRST_BLK;
            `CMD_PG_ONCE:
                bad = q.idx != `IDX_PROG || !phrase_ok(q.slot[1]);
            default: bad = 1'b1;
        endcase
        if (!q.cfg[`B_CMD_EN])
        begin
            bad = 1'b1;
        end
        prot_hit = cmd == `CMD_PG_MAIN && q.cfg[`B_PROT_EN]
            && blk >= q.cfg[14:8];
        if (bad)
        begin
            d.acc = 1'b1;
        end
        else if (prot_hit)
        begin
            d.fpv = 1'b1;
        end
        else
        begin
            d.ccf = 1'b0;
            d.fl.req = 1'b1;
            d.fl.wdata = {q.slot[2], q.slot[3], q.slot[4], q.slot[5]};
            d.fl.addr = {20'h0_0000, q.slot[1][2:0]};
            d.info = cmd != `CMD_PG_MAIN;
            case (cmd)
                `CMD_RD_ONCE:
                begin
                    d.st = S_RDO;
                    d.fl.op = OP_RD_INFO;
                    d.rd_inv_any = 1'b1;
                end
                `CMD_PG_MAIN:
                begin
                    d.st = S_PROG;
                    d.fl.op = OP_PG_MAIN;
                    d.fl.addr = {blk, q.slot[1]};
                end
                default:
                begin
                    d.st = S_ECHK;
                    d.fl.op = OP_RD_INFO;
                    d.rd_inv_b0 = 1'b1;
                end
            endcase
        end
    end
    // Sequence: each flash step is a held request ended by one ack
    if (q.st != S_IDLE)
    begin
        if (!q.fl.req)
        begin
            d.fl.req = 1'b1;
        end
        else if (fl_rsp.ack)
        begin
            d.fl.req = 1'b0;
            if (fl_rsp.err)
            begin
                d.ver = 1'b1;
            end
            if (fl_rsp.fatal)
            begin
                d.fat = 1'b1;
            end
            case (q.st)
                S_RDO:
                begin
                    for (int i = 0; i < 4; i++)
                    begin
                        d.slot[2 + i] = fl_rsp.rdata[63 - 16 * i -: 16];
                    end
                    d.st = S_IDLE;
                end
                // A programmed phrase can never be programmed again
                S_ECHK:
                begin
                    if (fl_rsp.rdata != `ERASED || fl_rsp.err)
                    begin
                        // Only ever sets: a flag pending from before must survive
                        if (fl_rsp.rdata != `ERASED)
                        begin
                            d.acc = 1'b1;
                        end
                        d.st = S_IDLE;
                    end
                    else
                    begin
                        d.st = S_PROG;
                        d.fl.op = OP_PG_INFO;
                    end
                end
                S_PROG:
                begin
                    d.st = S_VER;
                    d.fl.op = q.info ? OP_RD_INFO : OP_RD_MAIN;
                end
                S_VER:
                begin
                    if (fl_rsp.rdata != q.fl.wdata)
                    begin
                        d.ver = 1'b1;
                    end
                    d.st = S_IDLE;
                end
                default: d.st = S_IDLE;
            endcase
            if (d.st == S_IDLE)
            begin
                d.ccf = 1'b1;
                d.fl.req = 1'b0;
                d.rd_inv_any = 1'b0;
                d.rd_inv_b0 = 1'b0;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////

// State register
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        q <= '0;
        q.st <= S_IDLE;
        q.ccf <= 1'b1;
        q.cfg <= `RST_CONFIG;
    end
    else
    begin
        q <= d;
    end
end

// Every output is a flop of the state
assign pready = q.pready;
assign prdata = q.prdata;
assign pslverr = q.pslverr;
assign fl_cmd = q.fl;
assign rd_inv_any = q.rd_inv_any;
assign rd_inv_b0 = q.rd_inv_b0;

////////////////////////////////////////////////////////////////////////////////

// Checks on launch decisions and the sequence
property p_rd_idx;
    @(posedge pclk) disable iff (!presetn)
    launch && cmd == `CMD_RD_ONCE && !phrase_ok(q.slot[1]) |=> q.acc && q.ccf;
endproperty
a_rd_idx: assert property (p_rd_idx) else $error("bad index ran");

property p_rd_slot;
    @(posedge pclk) disable iff (!presetn)
    launch && cmd == `CMD_RD_ONCE && q.idx != 3'h1 |=> q.acc && q.st == S_IDLE;
endproperty
a_rd_slot: assert property (p_rd_slot) else $error("bad slot index");

property p_pg_slot;
    @(posedge pclk) disable iff (!presetn)
    launch && cmd[7:1] == 7'h03 && q.idx != 3'h5 |=> q.acc && q.ccf;
endproperty
a_pg_slot: assert property (p_pg_slot) else $error("program ran");

property p_align;
    @(posedge pclk) disable iff (!presetn)
    launch && cmd == `CMD_PG_MAIN && q.slot[1][2:0] != 3'b000
        |=> q.acc ##1 q.ccf;
endproperty
a_align: assert property (p_align) else $error("misaligned ran");

property p_mode;
    @(posedge pclk) disable iff (!presetn)
    launch && !q.cfg[0] |=> q.acc && !q.fl.req;
endproperty
a_mode: assert property (p_mode) else $error("mode not checked");

property p_rd_inv;
    @(posedge pclk) disable iff (!presetn)
    q.st == S_RDO |-> q.rd_inv_any && !q.ccf;
endproperty
a_rd_inv: assert property (p_rd_inv) else $error("reads not blocked");

property p_rd_nofpv;
    @(posedge pclk) disable iff (!presetn)
    q.st == S_RDO |=> !$rose(q.fpv);
endproperty
a_rd_nofpv: assert property (p_rd_nofpv) else $error("fpv in read");

property p_rd_data;
    @(posedge pclk) disable iff (!presetn)
    q.st == S_RDO && q.fl.req && fl_rsp.ack
        |=> q.ccf && q.slot[5] == $past(fl_rsp.rdata[15:0]);
endproperty
a_rd_data: assert property (p_rd_data) else $error("slots not filled");

property p_twice;
    @(posedge pclk) disable iff (!presetn)
    q.st == S_ECHK && q.fl.req && fl_rsp.ack && fl_rsp.rdata != `ERASED
        |=> q.acc && q.ccf && !q.rd_inv_b0;
endproperty
a_twice: assert property (p_twice) else $error("reprogrammed");

property p_done;
    @(posedge pclk) disable iff (!presetn)
    $rose(q.ccf) |-> $past(q.st) == S_VER || $past(q.st) == S_RDO
        || $past(q.st) == S_ECHK;
endproperty
a_done: assert property (p_done) else $error("early complete");

endmodule

// >>> test/flash_program_once_sequencer_bench.sv
/*
 Self-checking bench of the flash command sequencer.
 Plays the APB master and the flash array itself; pclk is 25 MHz.
*/
`timescale 1ns/100ps
`include "fpo_map.svh"
module flash_program_once_sequencer_bench import fpo_pkg::*;;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic pready, pslverr, rd_inv_any, rd_inv_b0, slverr;
    logic [31:0] prdata, rd, seed, fseed;
    fl_cmd_s fl_cmd;
    fl_rsp_s fl_rsp = '0;
    logic [63:0] otp [8];
    logic [63:0] main_q;
    logic [5:0] ops;
    logic inj_err = 0, inj_fat = 0, inv_any = 0, inv_b0 = 0;
    int err_total = 0, checks = 0, cyc = 0, nacks = 0;

    flash_program_once_sequencer i_flash_program_once_sequencer (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .fl_cmd(fl_cmd), .fl_rsp(fl_rsp),
        .rd_inv_any(rd_inv_any), .rd_inv_b0(rd_inv_b0));

    // Clock and hang guard
    always #20 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flash array: random wait, data only with ack, stale data inverted
    always @(posedge pclk)
    begin
        fl_rsp.ack <= 1'b0;
        fl_rsp.rdata <= ~fl_rsp.rdata;
        if (fl_cmd.req && !fl_rsp.ack)
        begin
            fseed <= lfsr(fseed);
            if (fseed[1:0] == 2'b00)
            begin
                fl_rsp.ack <= 1'b1;
                fl_rsp.err <= inj_err;
                fl_rsp.fatal <= inj_fat;
                inv_any <= rd_inv_any;
                inv_b0 <= rd_inv_b0;
                nacks <= nacks + 1;
                ops <= {ops[3:0], fl_cmd.op};
                case (fl_cmd.op)
                    OP_RD_INFO: fl_rsp.rdata <= otp[fl_cmd.addr[2:0]];
                    OP_RD_MAIN: fl_rsp.rdata <= main_q;
                    OP_PG_INFO: otp[fl_cmd.addr[2:0]] <= fl_cmd.wdata;
                    default: main_q <= fl_cmd.wdata;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [63:0] r64();
        seed = lfsr(lfsr(seed));
        return {seed, lfsr(seed) ^ 32'h5a5a_5a5a};
    endfunction

    // Expected status word with completion set
    function automatic logic [31:0] st(input logic acc, fpv, ver, fat);
        return {24'h00_0000, 2'b10, acc, fpv, 2'b00, ver, fat};
    endfunction

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // One APB transfer; request held until pready is sampled
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No own limit: only the hang guard ends a wait
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Clear flags, load slots, set index, launch, poll, check status and steps
    task automatic cmd(input logic [15:0] s0, s1, input logic [2:0] ix,
        input logic [63:0] d, input logic [31:0] es, input int ea, input string nm);
        logic [5:0][15:0] v;
        int a0;
        v = {d[15:0], d[31:16], d[47:32], d[63:48], s1, s0};
        a0 = nacks;
        apb(1'b1, `OFS_STATUS, 32'h0000_0030);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, `OFS_SLOT_IDX, 32'(i));
            apb(1'b1, `OFS_SLOT_DATA, {16'h0000, v[i]});
        end
        apb(1'b1, `OFS_SLOT_IDX, {29'h0000_0000, ix});
        apb(1'b1, `OFS_STATUS, 32'h0000_0080);
        do
        begin
            apb(1'b0, `OFS_STATUS, 32'h0000_0000);
        end while (rd[7] !== 1'b1);
        chk({nm, " status"}, rd, es);
        if (ea >= 0)
            chk({nm, " steps"}, 64'(nacks - a0), 64'(ea));
    endtask

    // Read back slots 2 to 5 as one phrase
    task automatic slots(input logic [63:0] exp, input string nm);
        logic [63:0] got;
        for (int i = 2; i < 6; i++)
        begin
            apb(1'b1, `OFS_SLOT_IDX, 32'(i));
            apb(1'b0, `OFS_SLOT_DATA, 32'h0000_0000);
            got = {got[47:0], rd[15:0]};
        end
        chk(nm, got, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [63:0] d;
        logic [15:0] lo;
        seed = 32'd83418;
        fseed = 32'd83418;
        main_q = 64'h0000_0000_0000_0000;
        for (int i = 0; i < 8; i++)
            otp[i] = `ERASED;
        otp[0] = r64();
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `OFS_CONFIG, 32'h0000_0000);
        chk("config", rd, 32'h0000_0001);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped", slverr, 1'b1);
        // Mode off refuses all three commands
        apb(1'b1, `OFS_CONFIG, 32'h0000_0000);
        // Slot 0 carries the code in its high byte, address bits 22 to 16 low
        cmd(16'h0400, 16'h0000, 3'h1, r64(), st(1, 0, 0, 0), 0, "off rd");
        cmd(16'h067c, 16'h0000, 3'h5, r64(), st(1, 0, 0, 0), 0, "off pg");
        cmd(16'h0700, 16'h0000, 3'h5, r64(), st(1, 0, 0, 0), 0, "off po");
        apb(1'b1, `OFS_CONFIG, 32'h0000_0001);
        // Read-once fetches phrase into slots
        cmd(16'h0400, 16'h0000, 3'h1, r64(), st(0, 0, 0, 0), 1, "rdo");
        slots(otp[0], "rdo data");
        chk("rdo inv", {inv_any, inv_b0}, 2'b10);
        // Refusals of index, slot index, code, alignment and block
        cmd(16'h0400, 16'h0008, 3'h1, r64(), st(1, 0, 0, 0), 0, "rdo idx");
        cmd(16'h0400, 16'h0000, 3'h5, r64(), st(1, 0, 0, 0), 0, "rdo ix");
        cmd(16'h0700, 16'h0008, 3'h5, r64(), st(1, 0, 0, 0), 0, "po idx");
        cmd(16'h0700, 16'h0001, 3'h1, r64(), st(1, 0, 0, 0), 0, "po ix");
        cmd(16'h067c, 16'h0000, 3'h4, r64(), st(1, 0, 0, 0), 0, "pg ix");
        cmd(16'h0500, 16'h0000, 3'h1, r64(), st(1, 0, 0, 0), 0, "code");
        cmd(16'h067c, 16'h0004, 3'h5, r64(), st(1, 0, 0, 0), 0, "pg mis");
        cmd(16'h0610, 16'h0000, 3'h5, r64(), st(1, 0, 0, 0), 0, "pg adr");
        // Program main: program then read back
        d = r64();
        lo = {seed[15:3], 3'b000};
        cmd(16'h067c, lo, 3'h5, d, st(0, 0, 0, 0), 2, "pg");
        chk("pg data", main_q, d);
        chk("pg ops", ops[3:0], {OP_PG_MAIN, OP_RD_MAIN});
        // Protection from block 0x7e upward
        apb(1'b1, `OFS_CONFIG, 32'h0000_fe01);
        cmd(16'h067f, lo, 3'h5, r64(), st(0, 1, 0, 0), 0, "prot");
        cmd(16'h067d, lo, 3'h5, r64(), st(0, 0, 0, 0), 2, "unprot");
        apb(1'b1, `OFS_CONFIG, 32'h0000_0001);
        // Flash errors during verify and read
        inj_err = 1'b1;
        inj_fat = 1'b1;
        // A fresh phrase: program main does no erased check, so a programmed one would be programmed again
        cmd(16'h067c, lo ^ 16'h0008, 3'h5, r64(), st(0, 0, 1, 1), -1, "pg err");
        inj_fat = 1'b0;
        cmd(16'h0400, 16'h0002, 3'h1, r64(), st(0, 0, 1, 0), -1, "rdo err");
        inj_err = 1'b0;
        // Program-once, second attempt refused, read back
        d = r64();
        cmd(16'h0700, 16'h0004, 3'h5, d, st(0, 0, 0, 0), 3, "po");
        chk("po ops", ops, {OP_RD_INFO, OP_PG_INFO, OP_RD_INFO});
        chk("po inv", {inv_any, inv_b0}, 2'b01);
        cmd(16'h0700, 16'h0004, 3'h5, r64(), st(1, 0, 0, 0), 1, "po again");
        cmd(16'h0400, 16'h0004, 3'h1, r64(), st(0, 0, 0, 0), 1, "rdo po");
        slots(d, "po data");
        end_sim();
    end
endmodule
